// [common/rtc_tick_regs.svh]
// What this block does
// - Wrap limit 16 bits, resets all ones
// - Wrap limit applies two counter cycles later
// - Match value 16 bits, resets to zero
// - Interval code selects 4 to 32768 cycles
// - Control bit 0 turns tick timer on
// - Tick control pending flag while synchronizing
// - Tick irq enable gates tick interrupt
// - Tick flag set on every tick
// - Writing one clears tick flag
// - Tick timer halted in debug unless run bit set; counter runs on
// - Run bit keeps ticking while CPU halted
// - Counter wraps to zero, sets wrap flag
// - Count equal match sets match flag
`ifndef RTC_TICK_REGS_SVH
`define RTC_TICK_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_SYNC_STATE   6'h01
`define IDX_WRAP_LO      6'h0A
`define IDX_WRAP_HI      6'h0B
`define IDX_MATCH_LO     6'h0C
`define IDX_MATCH_HI     6'h0D
`define IDX_TICK_CTRL    6'h10
`define IDX_TICK_STATE   6'h11
`define IDX_TICK_IEN     6'h12
`define IDX_TICK_FLAG    6'h13
`define IDX_TICK_DBG     6'h15
`define IDX_EVT_STATUS   6'h18
`define IDX_EVT_CLEAR    6'h19
`define IDX_EVT_ENABLE   6'h1A

`define WRAP_RESET       16'hFFFF
`define MATCH_RESET      16'h0000
`define BYTE_RESET       8'h00
`define SYNC_CYCLES      2'h2

`define TICK_ON_BIT      0
`define TICK_CODE_LSB    3
`define TICK_CODE_MSB    6
`define TICK_CODE_RSVD   4'hF
`define TICK_CTRL_MASK   8'h79

`define EVT_WRAP_BIT     0
`define EVT_MATCH_BIT    1
`define EVT_TICK_BIT     2

`endif

// [common/rtc_tick_pkg.sv]
package rtc_tick_pkg;
  typedef logic [15:0] word_t;
  typedef logic [7:0]  byte_t;
  typedef logic [1:0]  pend_t;
  typedef logic [7:0]  apb_addr_t;
  typedef logic [31:0] apb_data_t;
endpackage

// [src/rtc_tick_timer.sv]
`timescale 1ns/1ps
`include "rtc_tick_regs.svh"

module rtc_tick_timer (
  input  wire logic                   CLK_SYS_IN,
  input  wire logic                   RESET_IN,
  input  wire logic                   RTC_CLK_IN,
  input  wire logic                   DEBUG_HALT_IN,
  input  wire logic                   PSEL_IN,
  input  wire logic                   PENABLE_IN,
  input  wire logic                   PWRITE_IN,
  input  wire rtc_tick_pkg::apb_addr_t PADDR_IN,
  input  wire rtc_tick_pkg::apb_data_t PWDATA_IN,
  output rtc_tick_pkg::apb_data_t     PRDATA_OUT,
  output logic                        PREADY_OUT,
  output logic                        PSLVERR_OUT,
  output logic                        IRQ_OUT
);
  import rtc_tick_pkg::*;

  function automatic pend_t pend_next(input pend_t p, input logic wr, input logic stb);
    if (wr)
      pend_next = `SYNC_CYCLES;
    else if (stb && (p != 2'h0))
      pend_next = p - 2'h1;
    else
      pend_next = p;
  endfunction

  function automatic word_t tick_last(input logic [3:0] code);
    tick_last = (16'h0002 << code) - 16'h0001;
  endfunction

  function automatic logic mapped(input logic [5:0] idx);
    mapped = (idx == `IDX_SYNC_STATE) || (idx == `IDX_WRAP_LO) || (idx == `IDX_WRAP_HI) ||
             (idx == `IDX_MATCH_LO) || (idx == `IDX_MATCH_HI) || (idx == `IDX_TICK_CTRL) ||
             (idx == `IDX_TICK_STATE) || (idx == `IDX_TICK_IEN) || (idx == `IDX_TICK_FLAG) ||
             (idx == `IDX_TICK_DBG) || (idx == `IDX_EVT_STATUS) ||
             (idx == `IDX_EVT_CLEAR) || (idx == `IDX_EVT_ENABLE);
  endfunction

  // Counter clock is sampled; third stage only feeds the edge detect
  logic      rtc_s1_q, rtc_s2_q, rtc_s3_q;
  logic      halt_s1_q, halt_s2_q;
  logic      rtc_stb;
  byte_t     temp_q, temp_d;
  word_t     wrap_q, wrap_d, wrap_act_q, wrap_act_d;
  word_t     match_q, match_d, match_act_q, match_act_d;
  byte_t     tctl_q, tctl_d, tctl_act_q, tctl_act_d;
  logic      tick_ien_q, tick_ien_d;
  logic      dbg_q, dbg_d;
  logic      tick_flag_q, tick_flag_d;
  logic      wrap_flag_q, wrap_flag_d;
  logic      match_flag_q, match_flag_d;
  logic [1:0] evt_en_q, evt_en_d;
  pend_t     wrap_pend_q, wrap_pend_d;
  pend_t     match_pend_q, match_pend_d;
  pend_t     tctl_pend_q, tctl_pend_d;
  word_t     cnt_q, cnt_d;
  word_t     pit_q, pit_d;
  apb_data_t prdata_q, prdata_d;
  logic      err_q, err_d;
  logic [5:0] idx;
  logic      wr, rd_setup;
  logic      wr_wrap_lo, wr_wrap_hi, wr_match_lo, wr_match_hi, wr_tctl;
  logic      wrap_hit, match_hit, tick_run, tick_ev;
  logic [3:0] tick_code;
  byte_t     rd_byte;

  assign rtc_stb     = rtc_s2_q & ~rtc_s3_q;
  assign idx         = PADDR_IN[7:2];
  assign wr          = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign rd_setup    = PSEL_IN & ~PENABLE_IN;
  assign wr_wrap_lo  = wr && (idx == `IDX_WRAP_LO);
  assign wr_wrap_hi  = wr && (idx == `IDX_WRAP_HI);
  assign wr_match_lo = wr && (idx == `IDX_MATCH_LO);
  assign wr_match_hi = wr && (idx == `IDX_MATCH_HI);
  assign wr_tctl     = wr && (idx == `IDX_TICK_CTRL);
  assign tick_code   = tctl_act_q[`TICK_CODE_MSB:`TICK_CODE_LSB];
  // Reserved code 15 and code 0 never tick
  assign tick_run    = tctl_act_q[`TICK_ON_BIT] && (tick_code != 4'h0) &&
                       (tick_code != `TICK_CODE_RSVD);
  assign tick_ev     = tick_run && rtc_stb && !(halt_s2_q && !dbg_q) &&
                       (pit_q == tick_last(tick_code));
  assign wrap_hit    = rtc_stb && (cnt_q == wrap_act_q);
  assign match_hit   = rtc_stb && (cnt_d == match_act_q);

  always_comb begin
    rd_byte = 8'h00;
    if (idx == `IDX_SYNC_STATE) begin
      rd_byte = {7'h00, wrap_pend_q != 2'h0};
    end else if (idx == `IDX_WRAP_LO) begin
      rd_byte = wrap_q[7:0];
    end else if (idx == `IDX_WRAP_HI) begin
      rd_byte = wrap_q[15:8];
    end else if (idx == `IDX_MATCH_LO) begin
      rd_byte = match_q[7:0];
    end else if (idx == `IDX_MATCH_HI) begin
      rd_byte = match_q[15:8];
    end else if (idx == `IDX_TICK_CTRL) begin
      rd_byte = tctl_q;
    end else if (idx == `IDX_TICK_STATE) begin
      rd_byte = {7'h00, tctl_pend_q != 2'h0};
    end else if (idx == `IDX_TICK_IEN) begin
      rd_byte = {7'h00, tick_ien_q};
    end else if (idx == `IDX_TICK_FLAG) begin
      rd_byte = {7'h00, tick_flag_q};
    end else if (idx == `IDX_TICK_DBG) begin
      rd_byte = {7'h00, dbg_q};
    end else if (idx == `IDX_EVT_STATUS) begin
      rd_byte = {5'h00, tick_flag_q, match_flag_q, wrap_flag_q};
    end else if (idx == `IDX_EVT_ENABLE) begin
      rd_byte = {6'h00, evt_en_q};
    end
  end

  always_comb begin
    temp_d       = temp_q;
    wrap_d       = wrap_q;
    match_d      = match_q;
    tctl_d       = tctl_q;
    tick_ien_d   = tick_ien_q;
    dbg_d        = dbg_q;
    evt_en_d     = evt_en_q;
    wrap_act_d   = wrap_act_q;
    match_act_d  = match_act_q;
    tctl_act_d   = tctl_act_q;
    prdata_d     = prdata_q;
    err_d        = err_q;
    if (rd_setup) begin
      prdata_d = {24'h000000, rd_byte};
      err_d    = !mapped(idx);
    end
    // Low byte parks in temp so the pair commits at once
    if (wr_wrap_lo || wr_match_lo)
      temp_d = PWDATA_IN[7:0];
    if (wr_wrap_hi)
      wrap_d = {PWDATA_IN[7:0], temp_q};
    if (wr_match_hi)
      match_d = {PWDATA_IN[7:0], temp_q};
    if (wr_tctl)
      tctl_d = PWDATA_IN[7:0] & `TICK_CTRL_MASK;
    if (wr && (idx == `IDX_TICK_IEN))
      tick_ien_d = PWDATA_IN[0];
    if (wr && (idx == `IDX_TICK_DBG))
      dbg_d = PWDATA_IN[0];
    if (wr && (idx == `IDX_EVT_ENABLE))
      evt_en_d = PWDATA_IN[1:0];
    wrap_pend_d  = pend_next(wrap_pend_q, wr_wrap_hi, rtc_stb);
    match_pend_d = pend_next(match_pend_q, wr_match_hi, rtc_stb);
    tctl_pend_d  = pend_next(tctl_pend_q, wr_tctl, rtc_stb);
    // Copy into the counter side on the second counter edge
    if (rtc_stb && (wrap_pend_q == 2'h1) && !wr_wrap_hi)
      wrap_act_d = wrap_q;
    if (rtc_stb && (match_pend_q == 2'h1) && !wr_match_hi)
      match_act_d = match_q;
    if (rtc_stb && (tctl_pend_q == 2'h1) && !wr_tctl)
      tctl_act_d = tctl_q;
  end

  always_comb begin
    cnt_d = cnt_q;
    pit_d = pit_q;
    if (rtc_stb)
      cnt_d = (cnt_q == wrap_act_q) ? 16'h0000 : cnt_q + 16'h0001;
    if (!tick_run)
      pit_d = 16'h0000;
    else if (rtc_stb && !(halt_s2_q && !dbg_q))
      pit_d = tick_ev ? 16'h0000 : pit_q + 16'h0001;
  end

  always_comb begin
    wrap_flag_d  = wrap_flag_q;
    match_flag_d = match_flag_q;
    tick_flag_d  = tick_flag_q;
    if (wr && (idx == `IDX_EVT_CLEAR)) begin
      wrap_flag_d  = wrap_flag_q & ~PWDATA_IN[`EVT_WRAP_BIT];
      match_flag_d = match_flag_q & ~PWDATA_IN[`EVT_MATCH_BIT];
      tick_flag_d  = tick_flag_q & ~PWDATA_IN[`EVT_TICK_BIT];
    end
    if (wr && (idx == `IDX_TICK_FLAG))
      tick_flag_d = tick_flag_q & ~PWDATA_IN[0];
    // Set after clear so a same-cycle event survives
    if (wrap_hit)
      wrap_flag_d = 1'b1;
    if (match_hit)
      match_flag_d = 1'b1;
    if (tick_ev)
      tick_flag_d = 1'b1;
  end

  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rtc_s1_q     <= 1'b0;
      rtc_s2_q     <= 1'b0;
      rtc_s3_q     <= 1'b0;
      halt_s1_q    <= 1'b0;
      halt_s2_q    <= 1'b0;
      temp_q       <= `BYTE_RESET;
      wrap_q       <= `WRAP_RESET;
      wrap_act_q   <= `WRAP_RESET;
      match_q      <= `MATCH_RESET;
      match_act_q  <= `MATCH_RESET;
      tctl_q       <= `BYTE_RESET;
      tctl_act_q   <= `BYTE_RESET;
      tick_ien_q   <= 1'b0;
      dbg_q        <= 1'b0;
      evt_en_q     <= 2'h0;
      wrap_pend_q  <= 2'h0;
      match_pend_q <= 2'h0;
      tctl_pend_q  <= 2'h0;
      cnt_q        <= 16'h0000;
      pit_q        <= 16'h0000;
      wrap_flag_q  <= 1'b0;
      match_flag_q <= 1'b0;
      tick_flag_q  <= 1'b0;
      prdata_q     <= 32'h00000000;
      err_q        <= 1'b0;
    end else begin
      rtc_s1_q     <= RTC_CLK_IN;
      rtc_s2_q     <= rtc_s1_q;
      rtc_s3_q     <= rtc_s2_q;
      halt_s1_q    <= DEBUG_HALT_IN;
      halt_s2_q    <= halt_s1_q;
      temp_q       <= temp_d;
      wrap_q       <= wrap_d;
      wrap_act_q   <= wrap_act_d;
      match_q      <= match_d;
      match_act_q  <= match_act_d;
      tctl_q       <= tctl_d;
      tctl_act_q   <= tctl_act_d;
      tick_ien_q   <= tick_ien_d;
      dbg_q        <= dbg_d;
      evt_en_q     <= evt_en_d;
      wrap_pend_q  <= wrap_pend_d;
      match_pend_q <= match_pend_d;
      tctl_pend_q  <= tctl_pend_d;
      cnt_q        <= cnt_d;
      pit_q        <= pit_d;
      wrap_flag_q  <= wrap_flag_d;
      match_flag_q <= match_flag_d;
      tick_flag_q  <= tick_flag_d;
      prdata_q     <= prdata_d;
      err_q        <= err_d;
    end
  end

  assign PRDATA_OUT  = prdata_q;
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & err_q;
  assign IRQ_OUT     = (tick_flag_q & tick_ien_q) |
                       (wrap_flag_q & evt_en_q[0]) | (match_flag_q & evt_en_q[1]);

  chk_wrap_commit: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (rtc_stb && wrap_pend_q == 2'h1 && !wr_wrap_hi) |=> (wrap_act_q == $past(wrap_q)))
    else $error("wrap limit not applied on second counter edge");
  chk_wrap_wait: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    wr_wrap_hi |=> (wrap_act_q == $past(wrap_act_q)) && (wrap_pend_q == 2'h2))
    else $error("wrap limit applied too early");
  chk_wrap_zero: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    wrap_hit |=> (cnt_q == 16'h0000) && wrap_flag_q)
    else $error("counter did not wrap with flag");
  chk_match_set: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    match_hit |=> match_flag_q)
    else $error("match flag not set");
  chk_tick_busy: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    wr_tctl |=> (tctl_pend_q != 2'h0) ##0 (tctl_act_q == $past(tctl_act_q)))
    else $error("tick control pending flag missing");
  chk_tick_idle: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    !tctl_act_q[`TICK_ON_BIT] |-> !tick_ev ##1 (pit_q == 16'h0000))
    else $error("tick timer ran while off");
  chk_tick_len: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    tick_ev |-> (pit_q == ((16'h0004 << (tick_code - 4'h1)) - 16'h0001)) &&
                (tick_code != 4'h0) && (tick_code != `TICK_CODE_RSVD))
    else $error("tick interval wrong");
  chk_tick_commit: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (rtc_stb && tctl_pend_q == 2'h1 && !wr_tctl) |=> (tctl_act_q == $past(tctl_q)) && (tctl_pend_q == 2'h0))
    else $error("tick control not applied when pending ends");
  chk_tick_flag: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    tick_ev |=> tick_flag_q)
    else $error("tick flag not set");
  chk_tick_clear: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (wr && idx == `IDX_TICK_FLAG && !tick_ev) |=>
      (tick_flag_q == ($past(tick_flag_q) & ~$past(PWDATA_IN[0]))))
    else $error("tick flag clear wrong");
  chk_irq_gate: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (tick_flag_q && tick_ien_q) |-> IRQ_OUT)
    else $error("enabled tick flag gives no interrupt");
  chk_irq_quiet: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (!tick_ien_q && (evt_en_q == 2'h0)) |-> !IRQ_OUT)
    else $error("interrupt raised with every source disabled");
  chk_halt_hold: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (halt_s2_q && !dbg_q && tick_run) |=> (pit_q == $past(pit_q)))
    else $error("tick timer moved while halted");
  chk_halt_run: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (halt_s2_q && dbg_q && tick_run && rtc_stb && !tick_ev) |=> (pit_q == $past(pit_q) + 16'h0001))
    else $error("tick timer stopped despite run bit");
  chk_pair_atomic: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (wr_wrap_lo || wr_match_lo) |=> (wrap_q == $past(wrap_q)) && (match_q == $past(match_q)))
    else $error("low byte write changed live value");
  chk_match_commit: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    wr_match_hi |=> (match_q == {$past(PWDATA_IN[7:0]), $past(temp_q)}))
    else $error("match pair not committed whole");
endmodule

// [sim/rtc_tick_timer_bench.sv]
`timescale 1ns/1ps

module rtc_tick_timer_bench;
  import rtc_tick_pkg::*;
  typedef struct packed {
    logic      wr;
    apb_addr_t addr;
    byte_t     wdata;
    byte_t     rexp;
    logic      eexp;
  } row_s;
  logic      clk = 1'b0;
  logic      rst = 1'b1;
  logic      rtc = 1'b0;
  logic      halt = 1'b0;
  logic      psel = 1'b0;
  logic      pen = 1'b0;
  logic      pwr = 1'b0;
  apb_addr_t paddr = 8'h00;
  apb_data_t pwdata = 32'h00000000;
  apb_data_t prdata;
  logic      rdy;
  logic      err;
  logic      irq;
  apb_data_t rd;
  logic      er;
  int        err_count = 0;
  int        checks = 0;
  int        cyc = 0;
  int        t1;
  int        t2;
  byte_t     idle_cfg [3] = '{8'h08, 8'h01, 8'h79};
  row_s      rows [28] = '{
    '{1'b0, 8'h28, 8'h00, 8'hFF, 1'b0}, '{1'b0, 8'h2C, 8'h00, 8'hFF, 1'b0},
    '{1'b0, 8'h30, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h34, 8'h00, 8'h00, 1'b0},
    '{1'b0, 8'h40, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h44, 8'h00, 8'h00, 1'b0},
    '{1'b0, 8'h48, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h4C, 8'h00, 8'h00, 1'b0},
    '{1'b0, 8'h54, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h04, 8'h00, 8'h00, 1'b0},
    '{1'b0, 8'h60, 8'h00, 8'h00, 1'b0}, '{1'b1, 8'h44, 8'hFF, 8'h00, 1'b0},
    '{1'b0, 8'h44, 8'h00, 8'h00, 1'b0}, '{1'b1, 8'h30, 8'hA5, 8'h00, 1'b0},
    '{1'b1, 8'h34, 8'h5A, 8'h00, 1'b0}, '{1'b0, 8'h30, 8'h00, 8'hA5, 1'b0},
    '{1'b0, 8'h34, 8'h00, 8'h5A, 1'b0}, '{1'b1, 8'h40, 8'hFF, 8'h00, 1'b0},
    '{1'b0, 8'h40, 8'h00, 8'h79, 1'b0}, '{1'b1, 8'h40, 8'h00, 8'h00, 1'b0},
    '{1'b1, 8'h08, 8'h00, 8'h00, 1'b1}, '{1'b0, 8'h08, 8'h00, 8'h00, 1'b1},
    '{1'b0, 8'h64, 8'h00, 8'h00, 1'b0}, '{1'b1, 8'h48, 8'h01, 8'h00, 1'b0},
    '{1'b0, 8'h48, 8'h00, 8'h01, 1'b0}, '{1'b1, 8'h54, 8'h01, 8'h00, 1'b0},
    '{1'b0, 8'h54, 8'h00, 8'h01, 1'b0}, '{1'b1, 8'h54, 8'h00, 8'h00, 1'b0}};

  rtc_tick_timer uut (
    .CLK_SYS_IN    (clk),
    .RESET_IN      (rst),
    .RTC_CLK_IN    (rtc),
    .DEBUG_HALT_IN (halt),
    .PSEL_IN       (psel),
    .PENABLE_IN    (pen),
    .PWRITE_IN     (pwr),
    .PADDR_IN      (paddr),
    .PWDATA_IN     (pwdata),
    .PRDATA_OUT    (prdata),
    .PREADY_OUT    (rdy),
    .PSLVERR_OUT   (err),
    .IRQ_OUT       (irq)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  // Counter clock: eight system cycles a period, far below the sync limit
  initial begin
    forever begin
      repeat (4) @(posedge clk);
      rtc <= ~rtc;
    end
  end

  always @(posedge clk) cyc <= cyc + 1;

  task automatic check(input string name, input apb_data_t seen, input apb_data_t exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input apb_addr_t a, input byte_t d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    // Only the watchdog ends a stalled access
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    rd = prdata;
    er = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rdchk(input string name, input apb_addr_t a, input apb_data_t exp);
    apb(1'b0, a, 8'h00);
    check(name, rd, exp);
  endtask

  // Bounded wait for the interrupt line; returns the cycle stamp
  task automatic wait_irq(output int t);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq !== 1'b1 && n < 3000);
    check("irq_rise", {31'h0, irq}, 32'h1);
    t = cyc;
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    $display("BAD watchdog expected done seen hang");
    conclude();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[k]) begin
      apb(rows[k].wr, rows[k].addr, rows[k].wdata);
      check("pslverr", {31'h0, er}, {31'h0, rows[k].eexp});
      if (!rows[k].wr) check("row_read", rd, {24'h0, rows[k].rexp});
    end
    rdchk("wrap_idle", 8'h04, 32'h0);
    // Limit above the running count, else it rolls over at all ones first
    apb(1'b1, 8'h28, 8'h3F);
    apb(1'b1, 8'h2C, 8'h00);
    rdchk("wrap_pending", 8'h04, 32'h1);
    repeat (32) @(posedge clk);
    rdchk("wrap_pending_done", 8'h04, 32'h0);
    apb(1'b1, 8'h68, 8'h01);
    wait_irq(t1);
    rdchk("status_wrap", 8'h60, 32'h1);
    apb(1'b1, 8'h64, 8'h01);
    wait_irq(t1);
    apb(1'b1, 8'h64, 8'h01);
    wait_irq(t2);
    check("wrap_interval", 32'(t2 - t1), 32'd512);
    apb(1'b1, 8'h68, 8'h02);
    apb(1'b1, 8'h30, 8'h02);
    apb(1'b1, 8'h34, 8'h00);
    apb(1'b1, 8'h64, 8'h07);
    wait_irq(t1);
    apb(1'b0, 8'h60, 8'h00);
    check("status_match", rd & 32'h2, 32'h2);
    apb(1'b1, 8'h68, 8'h00);
    @(posedge clk);
    check("irq_masked", {31'h0, irq}, 32'h0);
    for (int c = 1; c < 5; c++) begin
      apb(1'b1, 8'h40, 8'((c << 3) | 1));
      wait_irq(t1);
      apb(1'b1, 8'h4C, 8'h01);
      wait_irq(t1);
      apb(1'b1, 8'h4C, 8'h01);
      wait_irq(t2);
      check("tick_interval", 32'(t2 - t1), 32'(8 << (c + 1)));
    end
    apb(1'b1, 8'h4C, 8'h00);
    rdchk("tick_flag_kept", 8'h4C, 32'h1);
    apb(1'b1, 8'h48, 8'h00);
    @(posedge clk);
    check("irq_gated", {31'h0, irq}, 32'h0);
    apb(1'b1, 8'h48, 8'h01);
    // Old setting may still tick until the new one has crossed over
    foreach (idle_cfg[j]) begin
      apb(1'b1, 8'h40, idle_cfg[j]);
      repeat (32) @(posedge clk);
      apb(1'b1, 8'h4C, 8'h01);
      repeat (300) @(posedge clk);
      rdchk("tick_idle", 8'h4C, 32'h0);
    end
    apb(1'b1, 8'h40, 8'h09);
    @(posedge clk);
    halt <= 1'b1;
    repeat (40) @(posedge clk);
    apb(1'b1, 8'h4C, 8'h01);
    repeat (300) @(posedge clk);
    rdchk("tick_halted", 8'h4C, 32'h0);
    apb(1'b1, 8'h54, 8'h01);
    wait_irq(t1);
    @(posedge clk);
    halt <= 1'b0;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    check("irq_reset", {31'h0, irq}, 32'h0);
    rst <= 1'b0;
    rdchk("ctrl_reset", 8'h40, 32'h0);
    rdchk("wrap_reset", 8'h28, 32'hFF);
    rdchk("match_reset", 8'h30, 32'h0);
    rdchk("flag_reset", 8'h4C, 32'h0);
    conclude();
  end
endmodule
